// ### logic/clk_rst_ctrl.sv
/*
  Core clock and chip reset sequencer with an APB register slave.
  Drives the analog PLL settings, tracks lock, selects the core clock source
  and generates the internal chip reset through a wake-up timer. Assumes the
  analog clock mux switches only on a registered select and that pclk is the
  oscillator reference.
*/
`timescale 1ns/1ps

// Overview of operation
// - Core clock is the oscillator unless the PLL is enabled, locked and connected.
// - Multiplier field selects any integer factor from 1 to 32.
// - Output divider field selects division by 2, 4, 8 or 16.
// - Division ratio is always even, so PLL output has 50 percent duty.
// - Any chip reset disables and bypasses the PLL.
// - Lock is reported 100 microseconds after enabling with stable settings.
// - Chip reset comes from the reset pin or the watchdog request.
// - The reset pin is glitch filtered before it can assert reset.
// - Internal reset holds until pin released, oscillator runs, count elapses, flash ready.
// - On reset release the processor fetches from address zero.
// - The wake-up delay applies after every kind of reset.
module clk_rst_ctrl
  import clk_rst_pkg::*;
(
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Reset sources and readiness.
  input  wire logic        ext_reset_pin_n,
  input  wire logic        wdt_reset_req,
  input  wire logic        osc_running,
  input  wire logic        flash_init_done,
  // Chip reset and boot.
  output logic             chip_reset_n,
  output logic      [31:0] boot_addr,
  // PLL control.
  output logic             pll_power,
  output logic      [5:0]  pll_mult,
  output logic      [4:0]  pll_div_ratio,
  output logic             pll_locked,
  output logic             core_clock_sel_pll
);

  function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] off);
    reg_hit = (addr[11:2] == off[11:2]);
  endfunction : reg_hit

  logic              ext_active;
  logic              osc_sync1_q;
  logic              osc_sync2_q;
  logic              reset_src;
  wake_state_t       wake_q;
  logic [11:0]       wake_cnt_q;
  logic              chip_reset_n_q;
  logic [1:0]        ctrl_q;
  logic [6:0]        cfg_q;
  logic [11:0]       lock_cnt_q;
  logic              lock_q;
  logic              sel_pll_q;
  logic              ext_cause_q;
  logic              wdt_cause_q;
  logic              wr_en;
  logic              rd_en;
  logic              mapped;
  logic [31:0]       rdata_d;
  logic [31:0]       prdata_q;
  logic [31:0]       boot_addr_q;
  logic [5:0]        mult_q;
  logic [4:0]        div_q;

  reset_pin_filter u_pin_filter (
    .pclk         (pclk),
    .presetn      (presetn),
    .pin_n        (ext_reset_pin_n),
    .pin_active_q (ext_active)
  );

  // The oscillator status comes from the analog domain.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_sync1_q <= 1'b0;
      osc_sync2_q <= 1'b0;
    end else begin
      osc_sync1_q <= osc_running;
      osc_sync2_q <= osc_sync1_q;
    end
  end

  assign reset_src = ext_active | wdt_reset_req;

  // Wake-up timer. Every source, pin or watchdog, goes through the same
  // count, so the oscillator always gets its settling time.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_q     <= WK_HOLD;
      wake_cnt_q <= 12'h000;
    end else if (reset_src) begin
      wake_q     <= WK_HOLD;
      wake_cnt_q <= 12'h000;
    end else begin
      case (wake_q)
        WK_HOLD: begin
          if (osc_sync2_q) begin
            wake_q     <= WK_COUNT;
            wake_cnt_q <= 12'h000;
          end
        end
        WK_COUNT: begin
          if (!osc_sync2_q) begin
            wake_q <= WK_HOLD;
          end else if (wake_cnt_q == WAKE_CYCLES - 12'h001) begin
            if (flash_init_done) begin
              wake_q <= WK_RUN;
            end
          end else begin
            wake_cnt_q <= wake_cnt_q + 12'h001;
          end
        end
        WK_RUN: begin
          wake_q <= WK_RUN;
        end
        default: begin
          wake_q <= WK_HOLD;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chip_reset_n_q <= 1'b0;
      boot_addr_q    <= BOOT_ADDR;
    end else begin
      chip_reset_n_q <= (wake_q == WK_RUN) && !reset_src;
      boot_addr_q    <= BOOT_ADDR;
    end
  end

  assign chip_reset_n = chip_reset_n_q;
  assign boot_addr    = boot_addr_q;

  // APB access. The slave answers in the access phase with no wait states.
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !penable && !pwrite;
  assign mapped  = reg_hit(paddr, CTRL_OFF) || reg_hit(paddr, CFG_OFF) ||
                   reg_hit(paddr, STAT_OFF);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (reg_hit(paddr, CTRL_OFF)) begin
      rdata_d[1:0] = ctrl_q;
    end else if (reg_hit(paddr, CFG_OFF)) begin
      rdata_d[6:0] = cfg_q;
    end else if (reg_hit(paddr, STAT_OFF)) begin
      rdata_d[STAT_LOCK_BIT]    = lock_q;
      rdata_d[STAT_ENABLED_BIT] = ctrl_q[CTRL_ENABLE_BIT];
      rdata_d[STAT_CONN_BIT]    = sel_pll_q;
      rdata_d[STAT_EXT_BIT]     = ext_cause_q;
      rdata_d[STAT_WDT_BIT]     = wdt_cause_q;
    end
  end

  // Read data is held in a register so it stays stable after the access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata_q <= rdata_d;
    end
  end

  assign prdata = prdata_q;

  // PLL control and configuration; cleared by any chip reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
      cfg_q  <= CFG_RESET;
    end else if (!chip_reset_n_q) begin
      ctrl_q <= CTRL_RESET;
      cfg_q  <= CFG_RESET;
    end else if (wr_en) begin
      if (reg_hit(paddr, CTRL_OFF)) begin
        ctrl_q <= pwdata[1:0];
      end
      if (reg_hit(paddr, CFG_OFF)) begin
        cfg_q <= pwdata[6:0];
      end
    end
  end

  // Settings are decoded into registered factors for the analog loop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mult_q <= 6'h01;
      div_q  <= 5'h02;
    end else begin
      mult_q <= {1'b0, cfg_q[CFG_MUL_LSB +: CFG_MUL_W]} + 6'h01;
      div_q  <= 5'h02 << cfg_q[CFG_DIV_LSB +: CFG_DIV_W];
    end
  end

  assign pll_mult      = mult_q;
  assign pll_div_ratio = div_q;
  assign pll_power     = ctrl_q[CTRL_ENABLE_BIT];

  // Lock timer. Writing new settings while running restarts the settling,
  // because the loop must re-acquire after any change of factors.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_cnt_q <= 12'h000;
      lock_q     <= 1'b0;
    end else if (!ctrl_q[CTRL_ENABLE_BIT] || (wr_en && reg_hit(paddr, CFG_OFF))) begin
      lock_cnt_q <= 12'h000;
      lock_q     <= 1'b0;
    end else if (lock_cnt_q == LOCK_CYCLES - 12'h001) begin
      lock_q <= 1'b1;
    end else begin
      lock_cnt_q <= lock_cnt_q + 12'h001;
    end
  end

  assign pll_locked = lock_q;

  // The select only changes from a flop, and drops before lock can be lost
  // by reconfiguration, so the mux never sees a runt pulse.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_pll_q <= 1'b0;
    end else begin
      sel_pll_q <= ctrl_q[CTRL_ENABLE_BIT] && ctrl_q[CTRL_CONNECT_BIT] && lock_q &&
                   !(wr_en && reg_hit(paddr, CFG_OFF)) && chip_reset_n_q;
    end
  end

  assign core_clock_sel_pll = sel_pll_q;

  // Reset cause flags: a new event wins over a write-one clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_cause_q <= 1'b0;
      wdt_cause_q <= 1'b0;
    end else begin
      if (ext_active) begin
        ext_cause_q <= 1'b1;
      end else if (wr_en && reg_hit(paddr, STAT_OFF) && pwdata[STAT_EXT_BIT]) begin
        ext_cause_q <= 1'b0;
      end
      if (wdt_reset_req) begin
        wdt_cause_q <= 1'b1;
      end else if (wr_en && reg_hit(paddr, STAT_OFF) && pwdata[STAT_WDT_BIT]) begin
        wdt_cause_q <= 1'b0;
      end
    end
  end

  // Properties that look one or two edges back allow for the registered
  // path from a request or a source to the output that shows it.
  a_bypass_unless_pll: assert property (@(posedge pclk) disable iff (!presetn)
    core_clock_sel_pll |-> pll_locked && pll_power)
    else $error("core clock taken from PLL without lock or power");

  a_mult_range: assert property (@(posedge pclk) disable iff (!presetn)
    $past(chip_reset_n_q) |-> pll_mult >= 6'h01 && pll_mult <= 6'h20)
    else $error("multiplier outside 1 to 32");

  a_div_even: assert property (@(posedge pclk) disable iff (!presetn)
    pll_div_ratio == 5'h02 || pll_div_ratio == 5'h04 ||
    pll_div_ratio == 5'h08 || pll_div_ratio == 5'h10)
    else $error("output divider not 2, 4, 8 or 16");

  a_reset_bypass: assert property (@(posedge pclk) disable iff (!presetn)
    !chip_reset_n |=> !pll_power && !core_clock_sel_pll)
    else $error("PLL active during chip reset");

  a_reset_factors: assert property (@(posedge pclk) disable iff (!presetn)
    !chip_reset_n |-> ##2 pll_mult == 6'h01 && pll_div_ratio == 5'h02)
    else $error("PLL factors not back to reset values after chip reset");

  a_lock_time: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(pll_locked) |-> lock_cnt_q == LOCK_CYCLES - 12'h001 && pll_power)
    else $error("lock reported at wrong time");

  a_lock_held: assert property (@(posedge pclk) disable iff (!presetn)
    pll_locked && pll_power && !(wr_en && reg_hit(paddr, CFG_OFF)) |=> pll_locked)
    else $error("lock lost without disable or reconfiguration");

  a_off_no_lock: assert property (@(posedge pclk) disable iff (!presetn)
    !pll_power |=> !pll_locked)
    else $error("lock reported while PLL is off");

  a_source_resets: assert property (@(posedge pclk) disable iff (!presetn)
    (ext_active || wdt_reset_req) |=> !chip_reset_n ##1 !chip_reset_n)
    else $error("reset source did not hold chip reset");

  a_cause_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
    ext_active |=> ext_cause_q)
    else $error("reset pin cause flag lost");

  a_wake_count: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(chip_reset_n) |-> $past(flash_init_done) &&
    $past(wake_cnt_q) == WAKE_CYCLES - 12'h001)
    else $error("chip reset released before wake-up complete");

  a_wake_needs_osc: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(chip_reset_n) |-> $past(osc_sync2_q, 2) && !$past(reset_src))
    else $error("chip reset released without oscillator or with a source active");

  a_boot_zero: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(chip_reset_n) |-> boot_addr == 32'h0000_0000)
    else $error("boot address not zero at reset release");

  a_lock_status: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && reg_hit(paddr, STAT_OFF) |=>
    prdata[STAT_LOCK_BIT] == $past(pll_locked))
    else $error("status read does not show lock");

  a_sel_after_lock: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(core_clock_sel_pll) |-> $past(pll_locked) && $past(pll_power))
    else $error("clock switched to PLL before lock");

  a_cfg_drops_sel: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && reg_hit(paddr, CFG_OFF) |=> !core_clock_sel_pll && !pll_locked)
    else $error("clock stayed on PLL across a reconfiguration");

endmodule : clk_rst_ctrl

// ### logic/clk_rst_pkg.sv
/*
  Shared constants of the clock and reset sequencer: register offsets, field
  positions, reset values and the cycle counts of the lock and wake-up timers.
  Assumes a 25 MHz APB clock that is also the oscillator reference.
*/
package clk_rst_pkg;

  // Clock and time base.
  localparam int unsigned CLK_PERIOD_NS   = 40;
  localparam int unsigned LOCK_TIME_NS    = 100000;
  localparam int unsigned LOCK_CYCLES_INT = LOCK_TIME_NS / CLK_PERIOD_NS;
  localparam logic [11:0] LOCK_CYCLES     = LOCK_CYCLES_INT[11:0];

  // Wake-up timer length and reset pin glitch filter length, in clocks.
  localparam logic [11:0] WAKE_CYCLES     = 12'h400;
  localparam logic [3:0]  FILTER_CYCLES   = 4'h8;

  // Register byte offsets.
  localparam logic [11:0] CTRL_OFF        = 12'h000;
  localparam logic [11:0] CFG_OFF         = 12'h004;
  localparam logic [11:0] STAT_OFF        = 12'h008;

  // Control register fields.
  localparam int unsigned CTRL_ENABLE_BIT  = 0;
  localparam int unsigned CTRL_CONNECT_BIT = 1;

  // Configuration register fields.
  localparam int unsigned CFG_MUL_LSB     = 0;
  localparam int unsigned CFG_MUL_W       = 5;
  localparam int unsigned CFG_DIV_LSB     = 5;
  localparam int unsigned CFG_DIV_W       = 2;

  // Status register fields.
  localparam int unsigned STAT_LOCK_BIT    = 0;
  localparam int unsigned STAT_ENABLED_BIT = 1;
  localparam int unsigned STAT_CONN_BIT    = 2;
  localparam int unsigned STAT_EXT_BIT     = 3;
  localparam int unsigned STAT_WDT_BIT     = 4;

  // Values after reset.
  localparam logic [1:0]  CTRL_RESET      = 2'h0;
  localparam logic [6:0]  CFG_RESET       = 7'h00;
  localparam logic [31:0] BOOT_ADDR       = 32'h0000_0000;

  typedef enum logic [2:0] {
    WK_HOLD  = 3'b001,
    WK_COUNT = 3'b010,
    WK_RUN   = 3'b100
  } wake_state_t;

endpackage : clk_rst_pkg

// ### logic/reset_pin_filter.sv
/*
  Reset pin conditioner: two-stage synchroniser followed by a glitch filter.
  Assumes the pin is asynchronous to pclk and active low.
*/
`timescale 1ns/1ps
module reset_pin_filter
  import clk_rst_pkg::*;
(
  // Clock and reset.
  input  wire logic pclk,
  input  wire logic presetn,
  // Pin and filtered level.
  input  wire logic pin_n,
  output logic      pin_active_q
);

  logic       sync1_q;
  logic       sync2_q;
  logic [3:0] stable_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= pin_n;
      sync2_q <= sync1_q;
    end
  end

  // A change of level must persist for the whole filter length to be taken.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stable_q     <= 4'h0;
      pin_active_q <= 1'b1;
    end else if (sync2_q == pin_active_q) begin
      if (stable_q == FILTER_CYCLES - 4'h1) begin
        pin_active_q <= ~sync2_q;
        stable_q     <= 4'h0;
      end else begin
        stable_q <= stable_q + 4'h1;
      end
    end else begin
      stable_q <= 4'h0;
    end
  end

  a_short_glitch: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(pin_active_q) |-> $past(sync2_q, 1) == $past(sync2_q, 8))
    else $error("reset pin filter passed a short pulse");

endmodule : reset_pin_filter

// ### tb/clk_rst_ctrl_bench.sv
/*
  Self-checking bench for the clock and reset sequencer, driven over APB.
  Assumes pclk is also the oscillator reference and pready needs no stall.
*/
`timescale 1ns/1ps
module clk_rst_ctrl_bench;
  import clk_rst_pkg::*;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ext_reset_pin_n;
  logic        wdt_reset_req;
  logic        osc_running;
  logic        flash_init_done;
  logic        chip_reset_n;
  logic [31:0] boot_addr;
  logic        pll_power;
  logic [5:0]  pll_mult;
  logic [4:0]  pll_div_ratio;
  logic        pll_locked;
  logic        core_clock_sel_pll;
  int          errors;
  int          tests_run;
  logic [31:0] rd;
  logic        err;
  int          n;
  int          mults [4] = '{1, 6, 32, 17};

  clk_rst_ctrl clk_rst_ctrl_inst (
    .pclk               (pclk),
    .presetn            (presetn),
    .psel               (psel),
    .penable            (penable),
    .pwrite             (pwrite),
    .paddr              (paddr),
    .pwdata             (pwdata),
    .prdata             (prdata),
    .pready             (pready),
    .pslverr            (pslverr),
    .ext_reset_pin_n    (ext_reset_pin_n),
    .wdt_reset_req      (wdt_reset_req),
    .osc_running        (osc_running),
    .flash_init_done    (flash_init_done),
    .chip_reset_n       (chip_reset_n),
    .boot_addr          (boot_addr),
    .pll_power          (pll_power),
    .pll_mult           (pll_mult),
    .pll_div_ratio      (pll_div_ratio),
    .pll_locked         (pll_locked),
    .core_clock_sel_pll (core_clock_sel_pll)
  );

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // One APB transfer; the request is held until pready is seen at an edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_rst(input logic lvl, input int lim);
    n = 0;
    while (chip_reset_n !== lvl && n < lim) begin
      @(posedge pclk);
      n++;
    end
  endtask : wait_rst

  task automatic cycles(input int c);
    repeat (c) @(posedge pclk);
  endtask : cycles

  initial begin
    #(40 * 40000);
    errors++;
    complete_run();
  end

  initial begin
    errors = 0;
    tests_run = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    ext_reset_pin_n = 1'b1;
    wdt_reset_req = 1'b0;
    osc_running = 1'b0;
    flash_init_done = 1'b0;
    cycles(8);
    chk("pll_power", 32'h0, 32'(pll_power));
    chk("sel_pll", 32'h0, 32'(core_clock_sel_pll));
    chk("pll_mult", 32'h1, 32'(pll_mult));
    chk("div_ratio", 32'h2, 32'(pll_div_ratio));
    presetn <= 1'b1;
    // Internal reset must wait for the oscillator and then for flash.
    cycles(1100);
    chk("rst_no_osc", 32'h0, 32'(chip_reset_n));
    osc_running <= 1'b1;
    cycles(1100);
    chk("rst_no_flash", 32'h0, 32'(chip_reset_n));
    flash_init_done <= 1'b1;
    wait_rst(1'b1, 10);
    chk("rst_release", 32'h1, 32'(chip_reset_n));
    chk("boot_addr", 32'h0, boot_addr);
    // Every divider code with a spread of multipliers, including both ends.
    // The PLL stays off here, so out-of-range products are never run.
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, CFG_OFF, 32'((mults[i] - 1) | (i << 5)));
      cycles(2);
      chk("pll_mult", 32'(mults[i]), 32'(pll_mult));
      chk("div_ratio", 32'(2 << i), 32'(pll_div_ratio));
      apb(1'b0, CFG_OFF, 32'h0);
      chk("cfg_read", 32'((mults[i] - 1) | (i << 5)), rd);
    end
    // Multiplier 2 and divider 4 give 50 MHz out and 200 MHz in the loop.
    apb(1'b1, CFG_OFF, 32'h21);
    apb(1'b1, CTRL_OFF, 32'h1);
    n = 0;
    while (pll_locked !== 1'b1 && n < 3000) begin
      @(posedge pclk);
      n++;
      if (n == 100) chk("sel_unlocked", 32'h0, 32'(core_clock_sel_pll));
    end
    chk("lock_time", 32'h1, 32'(n >= 2495 && n <= 2505));
    apb(1'b0, STAT_OFF, 32'h0);
    chk("stat_lock", 32'h3, rd & 32'h7);
    chk("pready", 32'h1, 32'(pready));
    apb(1'b1, CTRL_OFF, 32'h3);
    cycles(3);
    chk("sel_pll", 32'h1, 32'(core_clock_sel_pll));
    apb(1'b1, CFG_OFF, 32'h21);
    cycles(2);
    chk("sel_cfg_drop", 32'h0, 32'(core_clock_sel_pll));
    apb(1'b0, 12'h00C, 32'h0);
    chk("unmapped_err", 32'h1, 32'(err));
    chk("unmapped_rd", 32'h0, rd);
    // Watchdog pulse of one cycle must reset the chip and the PLL.
    cycles(3);
    @(posedge pclk);
    wdt_reset_req <= 1'b1;
    @(posedge pclk);
    wdt_reset_req <= 1'b0;
    cycles(3);
    chk("wdt_reset", 32'h0, 32'(chip_reset_n));
    chk("wdt_pll_off", 32'h0, 32'(pll_power));
    chk("wdt_lock_off", 32'h0, 32'(pll_locked));
    wait_rst(1'b1, 1200);
    chk("wake_len", 32'h1, 32'(n >= int'(WAKE_CYCLES) && n <= int'(WAKE_CYCLES) + 40));
    apb(1'b0, STAT_OFF, 32'h0);
    chk("stat_after_wdt", 32'h0, rd & 32'h7);
    apb(1'b0, CFG_OFF, 32'h0);
    chk("cfg_after_wdt", 32'h0, rd);
    // A short pin glitch is filtered; a long one resets the chip.
    @(posedge pclk);
    ext_reset_pin_n <= 1'b0;
    cycles(3);
    ext_reset_pin_n <= 1'b1;
    cycles(20);
    chk("pin_glitch", 32'h1, 32'(chip_reset_n));
    ext_reset_pin_n <= 1'b0;
    cycles(20);
    chk("pin_reset", 32'h0, 32'(chip_reset_n));
    cycles(1200);
    chk("pin_hold", 32'h0, 32'(chip_reset_n));
    ext_reset_pin_n <= 1'b1;
    wait_rst(1'b1, 1200);
    chk("pin_wake", 32'h1, 32'(n >= int'(WAKE_CYCLES) && n <= int'(WAKE_CYCLES) + 40));
    // Both reset causes are recorded and cleared by writing ones.
    apb(1'b0, STAT_OFF, 32'h0);
    chk("stat_causes", 32'h18, rd & 32'h1F);
    apb(1'b1, STAT_OFF, 32'h18);
    apb(1'b0, STAT_OFF, 32'h0);
    chk("stat_cleared", 32'h0, rd & 32'h1F);
    complete_run();
  end
endmodule : clk_rst_ctrl_bench
